/* File: rtl/fxmul_pkg.sv */
// Shared constants and types for the configurable fixed-point multiplier.
package fxmul_pkg;

  // Operand width range in which a hard core form may be chosen.
  localparam int CORE_WIDTH_MIN = 2;
  localparam int CORE_WIDTH_MAX = 32;

  // Least second-operand width for the pipelined core form.
  localparam int PIPE_B_MIN = 3;

  // Upper bounds of the second-operand width bands for core latency.
  localparam int LAT_BAND1_MAX = 4;
  localparam int LAT_BAND2_MAX = 8;
  localparam int LAT_BAND3_MAX = 16;

  // Core latency in clocks for each band.
  localparam int LAT_BAND1 = 1;
  localparam int LAT_BAND2 = 2;
  localparam int LAT_BAND3 = 3;
  localparam int LAT_BAND4 = 4;

  // Reset value of every pipeline stage.
  localparam int STAGE_RESET = 0;

  // Realisation form of the multiplier.
  typedef enum logic [1:0] {
    FORM_PIPE_CORE = 2'b00,
    FORM_PAR_CORE  = 2'b01,
    FORM_GENERIC   = 2'b10
  } mult_form_t;

  // Latency of the pipelined core as a function of the second width.
  function automatic int core_latency(input int b_width);
    int lat;
    lat = LAT_BAND4;
    if (b_width <= LAT_BAND1_MAX) begin
      lat = LAT_BAND1;
    end else if (b_width <= LAT_BAND2_MAX) begin
      lat = LAT_BAND2;
    end else if (b_width <= LAT_BAND3_MAX) begin
      lat = LAT_BAND3;
    end
    return lat;
  endfunction

endpackage

/* File: rtl/fxmul_stage_if.sv */
// Interface carrying a product word between the core and the delay chain.
`timescale 1ns/10ps
interface fxmul_stage_if #(
  parameter int W = 16
);
  logic [W-1:0] data;   // Product word.

  modport src (output data);
  modport dst (input  data);
endinterface

/* File: rtl/fxmul_delay.sv */
// Register chain that delays a product word by a set number of clocks.
`timescale 1ns/10ps
module fxmul_delay #(
  parameter int W     = 16,
  parameter int DEPTH = 1
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  fxmul_stage_if.dst  in_if,
  output logic [W-1:0] q_o
);
  import fxmul_pkg::*;

  // Stage storage; index 0 is nearest the core.
  logic [W-1:0] st_q [DEPTH];
  logic [W-1:0] st_d [DEPTH];

  // Next values shift the chain by one each clock.
  always_comb begin
    st_d[0] = in_if.data;
    for (int i = 1; i < DEPTH; i++) begin
      st_d[i] = st_q[i-1];
    end
  end

  // Registers only; reset clears every stage so no stale data leaks.
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_stage
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        st_q[g] <= W'(STAGE_RESET);
      end else begin
        st_q[g] <= st_d[g];
      end
    end
  end

  // Last stage drives the output.
  assign q_o = st_q[DEPTH-1];

endmodule

/* File: rtl/fxmul_top.sv */
// Configurable fixed-point multiplier with core, parallel and generic forms.
`timescale 1ns/10ps
module fxmul_top #(
  parameter int A_WIDTH  = 16,  // First operand width.
  parameter int B_WIDTH  = 16,  // Second operand width.
  parameter bit A_SIGNED = 1'b1,  // First operand is two's complement.
  parameter bit B_SIGNED = 1'b1,  // Second operand is two's complement.
  parameter int LATENCY  = 3,   // Configured latency in clocks.
  parameter bit USE_CORE = 1'b1,  // Prefer a core form when legal.
  parameter bit PIPELINE = 1'b1   // Ask for the pipelined form.
) (
  input  wire logic                       CLK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic [A_WIDTH-1:0]         A_I,
  input  wire logic [B_WIDTH-1:0]         B_I,
  output logic [A_WIDTH+B_WIDTH-1:0]      P_O,
  output fxmul_pkg::mult_form_t           FORM_O
);
  import fxmul_pkg::*;

  localparam int PW = A_WIDTH + B_WIDTH;  // Full product width.

  // The three forms differ only in where the registers sit. The pipelined
  // form puts the core's own stages first and pads the rest behind them;
  // the parallel forms keep the multiply flat and register its output.
  // Every form is inferred from one multiply, which gives up the area of a
  // hard core in return for one model that behaves alike on every target.
  // A neighbour therefore sees the latency, and the form only on FORM_O.

  // Core forms are legal only inside the width range.
  localparam bit WIDTHS_OK =
    (A_WIDTH >= CORE_WIDTH_MIN) && (A_WIDTH <= CORE_WIDTH_MAX) &&
    (B_WIDTH >= CORE_WIDTH_MIN) && (B_WIDTH <= CORE_WIDTH_MAX);

  // Latency the pipelined core itself contributes.
  // It is fixed by the second operand width alone.
  localparam int CORE_LAT = core_latency(B_WIDTH);

  // Pipelined form: asked for, core allowed, wide B, enough latency.
  localparam bit PIPE_OK = PIPELINE && USE_CORE && WIDTHS_OK &&
                           (B_WIDTH >= PIPE_B_MIN) && (LATENCY >= CORE_LAT);

  // Form actually built; falls back to generic when a core is barred.
  // Without the core option every width that passes the refusals below ends up
  // in generic logic, so the option only ever widens the choice, never narrows it.
  localparam mult_form_t FORM =
    PIPE_OK                 ? FORM_PIPE_CORE :
    (USE_CORE && WIDTHS_OK && !PIPELINE) ? FORM_PAR_CORE : FORM_GENERIC;

  // Stages inside the multiplier and stages appended after it.
  localparam int INNER = (FORM == FORM_PIPE_CORE) ? CORE_LAT : 0;
  localparam int OUTER = LATENCY - INNER;

  // Elaboration-time refusal of configurations that cannot be honoured.
  // Refusing here, rather than silently falling back, keeps a latency the
  // neighbours were built around from changing without notice.
  if (PIPELINE && (B_WIDTH < PIPE_B_MIN)) begin : g_bad_b
    $error("Pipelined form needs a second operand wider than two bits.");
  end
  if (PIPELINE && WIDTHS_OK &&
      (LATENCY < CORE_LAT)) begin : g_bad_lat
    $error("Configured latency is below the pipelined core latency.");
  end
  if (PIPELINE && !WIDTHS_OK) begin : g_bad_w
    $error("Pipelined form needs both widths within the core range.");
  end
  if (LATENCY < 0) begin : g_bad_neg
    $error("Latency must not be negative.");
  end

  // Sign-extended operands so one signed multiply covers every mix.
  logic signed [A_WIDTH:0] a_ext;
  logic signed [B_WIDTH:0] b_ext;
  logic signed [PW+1:0]    prod_full;
  logic [PW-1:0]           prod_comb;

  // Combinational product shared by all forms.
  // One extra bit per operand turns an unsigned operand into a positive
  // signed one, so the same multiply serves every mix of signedness.
  always_comb begin
    a_ext     = {A_SIGNED & A_I[A_WIDTH-1], A_I};
    b_ext     = {B_SIGNED & B_I[B_WIDTH-1], B_I};
    prod_full = a_ext * b_ext;
    prod_comb = prod_full[PW-1:0];
  end

  // Form indicator is a constant level from reset onward.
  assign FORM_O = FORM;

  // Inner core pipeline, present only in the pipelined form.
  // The core's stages are modelled as registers behind the flat product;
  // only the count of stages is visible at the pins. The same interface
  // then carries the core result on to the output chain.
  fxmul_stage_if #(.W(PW)) core_if ();
  logic [PW-1:0] core_out;

  if (INNER > 0) begin : g_core_pipe
    fxmul_stage_if #(.W(PW)) in_if ();
    assign in_if.data = prod_comb;
    // Core latency taken from the B width band.
    fxmul_delay #(.W(PW), .DEPTH(INNER)) u_core (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .in_if (in_if),
      .q_o   (core_out)
    );
  end else begin : g_core_flat
    assign core_out = prod_comb;
  end
  assign core_if.data = core_out;

  // Extra output stages make up the remaining latency.
  // In the parallel forms this chain carries the whole latency.
  if (OUTER > 0) begin : g_out_pipe
    fxmul_delay #(.W(PW), .DEPTH(OUTER)) u_out (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .in_if (core_if),
      .q_o   (P_O)
    );
  end else begin : g_out_flat
    // Zero latency leaves a purely combinational path; a limitation the
    // neighbouring block must budget in its own timing.
    assign P_O = core_out;
  end

  // Checks: latency total and product value after exactly LATENCY clocks.
  // The reference line below is a second, independent delay of the flat
  // product; fill_q marks how many of its slots hold data taken since the
  // last reset, so the product value checks do not fire on the cleared stages.
  if (LATENCY > 0) begin : g_chk
    logic [PW-1:0] ref_q [LATENCY];   // Reference delay line.
    logic [LATENCY-1:0] fill_q;       // Marks which slots hold real data.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        fill_q <= '0;
        for (int i = 0; i < LATENCY; i++) begin
          ref_q[i] <= '0;
        end
      end else begin
        // Shift a one in; the cast keeps the low LATENCY bits, so a
        // latency of one needs no special case.
        fill_q   <= LATENCY'({fill_q, 1'b1});
        ref_q[0] <= prod_comb;
        for (int i = 1; i < LATENCY; i++) begin
          ref_q[i] <= ref_q[i-1];
        end
      end
    end

    a_product_delay: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      fill_q[LATENCY-1] |-> (P_O == ref_q[LATENCY-1]))
      else $error("Product does not match operands LATENCY clocks ago.");

    a_stage_split: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (INNER + OUTER == LATENCY) && (OUTER >= 0))
      else $error("Inner and outer stages do not sum to the latency.");

    a_core_latency: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (FORM == FORM_PIPE_CORE) |-> (INNER == CORE_LAT && LATENCY >= INNER))
      else $error("Pipelined form latency below core latency.");

    a_pipe_width: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (FORM == FORM_PIPE_CORE) |-> (B_WIDTH >= PIPE_B_MIN))
      else $error("Pipelined form with a two-bit second operand.");

    a_core_range: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (FORM != FORM_GENERIC) |-> WIDTHS_OK)
      else $error("Core form chosen outside the width range.");

    a_core_pref: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (USE_CORE && WIDTHS_OK && !PIPELINE) |-> (FORM_O == FORM_PAR_CORE))
      else $error("Parallel core not used where it was allowed.");

    a_pipe_select: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (FORM_O == FORM_PIPE_CORE) |-> PIPELINE)
      else $error("Pipelined form without the pipeline option.");

    a_form_stable: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      $stable(FORM_O))
      else $error("Form indicator changed during operation.");

    a_band_value: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (B_WIDTH >= 17) |-> (CORE_LAT == 4))
      else $error("Core latency wrong for a wide second operand.");

    a_lead_zero: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !fill_q[LATENCY-1] |-> (P_O == '0))
      else $error("Product appeared before the configured latency.");

    a_past_product: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      fill_q[LATENCY-1] |-> (P_O == $past(prod_comb, LATENCY)))
      else $error("Product is not that of operands LATENCY clocks ago.");

    a_reset_zero: assert property (
      @(posedge CLK_I)
      SYS_RST_I |-> (P_O == '0))
      else $error("Product not cleared while reset is held.");
  end

endmodule

/* File: tb/fxmul_src.sv */
// Operand source standing in for the upstream datapath blocks.
`timescale 1ns/10ps
module fxmul_src #(
  parameter int AW = 8,
  parameter int BW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          en_i,
  output logic [AW-1:0]      a_o,
  output logic [BW-1:0]      b_o
);
  int   k;     // Step of the operand pattern.
  logic run;   // Enable as sampled at the edge, free of races.

  // New operands just after every edge; sign corners come first.
  // Zero while idle, so a reset never meets stale operands.
  always @(posedge clk_i) begin
    run = en_i;
    #1;
    if (run) begin
      k = k + 1;
      a_o = (k == 1) ? {1'b1, {(AW-1){1'b0}}} : AW'(k * 157 + 3);
      b_o = (k < 3) ? {1'b1, {(BW-1){1'b0}}} : BW'((k * 91) ^ 45);
    end else begin
      k = 0;
      a_o = '0;
      b_o = '0;
    end
  end

  // Quiet operands from time zero.
  initial begin
    k = 0;
    a_o = '0;
    b_o = '0;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the multiplier in all three forms.
`timescale 1ns/10ps
module tb;
  import fxmul_pkg::*;
  logic        clk;              // System clock, 8 ns period.
  logic        rst;              // Active-high reset.
  logic        en;               // Lets the operand sources run.
  int          fail_count;       // Mismatches seen.
  int          samples_checked;  // Comparisons made.
  localparam int AW   = 8;     // First operand width of every instance.
  localparam int BW0  = 16;    // Picks a core latency of three.
  localparam int BW1  = 8;     // Parallel and fallback instances.
  localparam int BW2  = 40;    // Too wide for any core form.
  localparam int BW3  = 4;     // Narrowest band: core latency of one.
  localparam int LAT0 = 5;     // Three core stages and two extra ones.
  localparam int LAT1 = 2;     // Two output stages.
  localparam int LAT2 = 0;     // No stage at all.
  localparam int LAT3 = 1;     // One stage.
  localparam bit OFF  = 1'b0;  // An option switched off.
  logic [7:0]  a0, a1, b1, a2;   // Operands of narrow width.
  logic [15:0] b0;               // Second operand of the pipelined form.
  logic [39:0] b2;               // Second operand of the generic form.
  logic [23:0] p0;               // Products.
  logic [15:0] p1;
  logic [47:0] p2;
  logic [11:0] p3;
  logic [15:0] p4;
  mult_form_t  f0, f1, f2, f3, f4;  // Forms built.
  logic [63:0] h0 [6];           // Expected products, newest first.
  logic [63:0] h1 [3];
  logic [63:0] h2;
  logic [63:0] h3 [2];
  logic [63:0] h4 [2];

  // Pipelined core of latency three, padded to five by extra stages.
  fxmul_top #(.A_WIDTH(AW), .B_WIDTH(BW0), .LATENCY(LAT0)) fxmul_top_inst (
    .CLK_I(clk), .SYS_RST_I(rst), .A_I(a0), .B_I(b0), .P_O(p0), .FORM_O(f0));
  // Parallel core with two output stages.
  fxmul_top #(.A_WIDTH(AW), .B_WIDTH(BW1), .LATENCY(LAT1), .PIPELINE(OFF))
    fxmul_top_inst_par (.CLK_I(clk), .SYS_RST_I(rst), .A_I(a1), .B_I(b1),
    .P_O(p1), .FORM_O(f1));
  // Combinational generic form, although the core option is on.
  fxmul_top #(.A_WIDTH(AW), .B_WIDTH(BW2), .LATENCY(LAT2), .PIPELINE(OFF))
    fxmul_top_inst_gen (.CLK_I(clk), .SYS_RST_I(rst), .A_I(a2), .B_I(b2),
    .P_O(p2), .FORM_O(f2));
  // Unsigned pipelined core of the narrowest band, with no extra stage.
  fxmul_top #(.A_WIDTH(AW), .B_WIDTH(BW3), .A_SIGNED(OFF), .B_SIGNED(OFF),
    .LATENCY(LAT3)) fxmul_top_inst_band (.CLK_I(clk), .SYS_RST_I(rst),
    .A_I(a1), .B_I(b1[BW3-1:0]), .P_O(p3), .FORM_O(f3));
  // Core option off: generic logic with one output stage.
  fxmul_top #(.A_WIDTH(AW), .B_WIDTH(BW1), .LATENCY(LAT3), .USE_CORE(OFF),
    .PIPELINE(OFF)) fxmul_top_inst_fall (.CLK_I(clk), .SYS_RST_I(rst),
    .A_I(a1), .B_I(b1), .P_O(p4), .FORM_O(f4));
  fxmul_src #(.AW(AW), .BW(BW0)) fxmul_src_inst (.clk_i(clk), .en_i(en),
    .a_o(a0), .b_o(b0));
  fxmul_src #(.AW(AW), .BW(BW1)) fxmul_src_inst_par (.clk_i(clk), .en_i(en),
    .a_o(a1), .b_o(b1));
  fxmul_src #(.AW(AW), .BW(BW2)) fxmul_src_inst_gen (.clk_i(clk), .en_i(en),
    .a_o(a2), .b_o(b2));

  // Free-running clock.
  always #4 clk = ~clk;

  // Compares the low w bits; an unknown bit never passes.
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g, input int w);
    logic [63:0] m;
    m = (64'h1 << w) - 64'h1;
    samples_checked++;
    if (((e ^ g) & m) !== 64'h0) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e & m, g & m);
    end
  endtask

  // Stages hold zero after reset, and so do the histories.
  task automatic clr_hist();
    h0 = '{default: 64'h0};
    h1 = '{default: 64'h0};
    h2 = 64'h0;
    h3 = '{default: 64'h0};
    h4 = '{default: 64'h0};
  endtask

  // Forms chosen from widths and options.
  task automatic t_form();
    chk("form pipe", 64'(FORM_PIPE_CORE), 64'(f0), 2);
    chk("form par", 64'(FORM_PAR_CORE), 64'(f1), 2);
    chk("form gen", 64'(FORM_GENERIC), 64'(f2), 2);
    chk("form band", 64'(FORM_PIPE_CORE), 64'(f3), 2);
    chk("form fall", 64'(FORM_GENERIC), 64'(f4), 2);
  endtask

  // Back-to-back operands; each product lands exactly on its latency.
  task automatic t_stream(input int n);
    repeat (n) begin
      @(negedge clk);
      for (int i = 5; i > 0; i--)
        h0[i] = h0[i-1];
      h0[0] = 64'($signed(a0)) * 64'($signed(b0));
      h1[2] = h1[1];
      h1[1] = h1[0];
      h1[0] = 64'($signed(a1)) * 64'($signed(b1));
      h2 = 64'($signed(a2)) * 64'($signed(b2));
      h3[1] = h3[0];
      h3[0] = 64'(a1) * 64'(b1[BW3-1:0]);
      h4[1] = h4[0];
      h4[0] = 64'($signed(a1)) * 64'($signed(b1));
      chk("band", h3[1], 64'(p3), 12);
      chk("fall", h4[1], 64'(p4), 16);
      chk("pipe", h0[5], 64'(p0), 24);
      chk("par", h1[2], 64'(p1), 16);
      chk("gen", h2, 64'(p2), 48);
    end
  endtask

  // Reset in mid-stream clears every stage at once.
  task automatic t_reset();
    @(posedge clk);
    #1 rst = 1'b1;
    en = 1'b0;
    repeat (3) begin
      @(negedge clk);
      chk("rst pipe", 64'h0, 64'(p0), 24);
      chk("rst par", 64'h0, 64'(p1), 16);
      chk("rst band", 64'h0, 64'(p3), 12);
      chk("rst fall", 64'h0, 64'(p4), 16);
    end
    clr_hist();
    @(posedge clk);
    #1 rst = 1'b0;
    en = 1'b1;
  endtask

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    en = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    clr_hist();
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    en = 1'b1;
    t_form();
    t_stream(40);
    t_reset();
    t_stream(40);
    finish_test();
  end

  // The run needs about a hundred cycles; this is far beyond that.
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
